/* design/ued_cfg.svh */
`ifndef UED_CFG_SVH
`define UED_CFG_SVH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define UED_A_PWR   8'h87
`define UED_A_CTL   8'h98
`define UED_A_DATA  8'h99
`define UED_A_AUX   8'hA2
`define UED_A_STAT  8'hBA

// ----------------------------------------
// Field positions
// ----------------------------------------
`define UED_B_SMOD1 7
`define UED_B_FRAME_ERROR_VIEW_SELECT 6
`define UED_B_BREAK_RESET_ENABLE  6
`define UED_B_FE    3

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define UED_RST8    8'h00
`define UED_MID     4'h7
`define UED_LAST    4'hF
`define UED_BRK     4'hB
`define UED_BIT7    3'h7

`endif

/* design/ued_pkg.sv */
package ued_pkg;

    typedef enum logic [2:0] {
        RX_IDLE  = 3'h0,
        RX_START = 3'h1,
        RX_DATA  = 3'h3,
        RX_NINTH = 3'h2,
        RX_STOP  = 3'h6,
        RX_LOW   = 3'h7,
        RX_SHIFT = 3'h5
    } ued_rx_state_e;

    typedef enum logic [2:0] {
        TX_IDLE  = 3'h0,
        TX_START = 3'h1,
        TX_DATA  = 3'h3,
        TX_NINTH = 3'h2,
        TX_STOP  = 3'h6,
        TX_SHIFT = 3'h5
    } ued_tx_state_e;

endpackage : ued_pkg

/* design/ued_uart.sv */
`timescale 1ns/100ps
`include "ued_cfg.svh"

// What this block does
// - Stop bit sampled low flags a framing error.
// - Control bit 7 is framing error when view select is 1, else mode high.
// - Eleven consecutive low bit samples set line_low_flag.
// - A break also sets the framing error flag.
// - After a break, receiver idles until a high bit is sampled.
// - Break with break_reset_enable resets device into programming mode.
// - rx_done_flag: end of bit 8 in mode 0, mid stop in mode 1.
// - Modes 2/3: rx_done at mid ninth bit, or mid stop if view select.
// - tx_done: end of bit 8 in mode 0, stop bit per timing select.
// - rx_ninth_bit holds ninth bit in modes 2/3, stop bit in mode 1.
// - Modes 2/3 transmit tx_ninth_bit as ninth data bit.
// - Reception only while receive_enable is set.
// - Multiprocessor mode suppresses rx_done in modes 2/3 when ninth bit is 0.
// - Framing error stays set until software writes it.
// - Mode pair selects shift register or 8/9-bit UART and rate.
// - Reset gives mode 0, view select 0, done flags 0.
// - Break is reported in status register, apart from done flags.
// - Buffer load in modes 1-3 with rx_done still set sets overrun_flag.
// - status_irq_enable lets error flags raise the serial interrupt.
// - Status framing error sets on invalid stop, cleared by software.
module ued_uart
    import ued_pkg::*;
(
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_n,
    // Register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // Variable rate sixteenth-bit tick
    input  wire logic       baud_tick16,
    // Serial pins
    input  wire logic       rxd_in,
    output logic            rxd_out,
    output logic            rxd_oe,
    output logic            txd_out,
    // System
    output logic            serial_irq,
    output logic            brk_reset_req,
    output logic            isp_entry_req
);

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    logic          sm0_r, sm1_r, sm2_r, ren_r, tb8_r, rb8_r, ti_r, ri_r;
    logic          fe_r, br_r, oe_r, status_irq_enable_r;
    logic          double_buffer_enable_r, tx_irq_timing_select_r, combined_irq_disable_r, double_buffer_irq_select_r;
    logic          smod1_r, frame_error_view_select_r, break_reset_enable_r;
    logic    [7:0] rx_buf_r;
    logic    [7:0] rdata_r;
    logic          div_r;
    logic          tick;
    logic    [1:0] mode;
    logic          wr_ctl, wr_stat, wr_data;

    // Hardware events
    logic          ri_ev_r, ti_ev_r, fe_ev_r, br_ev_r, oe_ev_r;
    logic          rb8_ev_r, rb8_val_r;
    logic    [7:0] buf_val_r;

    // Receiver
    ued_rx_state_e rx_st_r;
    logic    [3:0] rx_tc_r;
    logic    [2:0] rx_bit_r;
    logic    [7:0] rx_sh_r;
    logic          rx_b9_r;
    logic    [3:0] low_r;
    logic    [3:0] low_nxt;
    logic          samp;
    logic          ninth_ok;

    // Transmitter
    ued_tx_state_e tx_st_r;
    logic    [3:0] tx_tc_r;
    logic    [2:0] tx_bit_r;
    logic    [7:0] tx_sh_r;
    logic          tx_b9_r;
    logic          tx_end;

    // Outputs
    logic          txd_r, rxo_r, rxoe_r, irq_r, brst_r, isp_r;

    assign mode    = {sm0_r, sm1_r};
    assign wr_ctl  = reg_wr && (reg_addr == `UED_A_CTL);
    assign wr_stat = reg_wr && (reg_addr == `UED_A_STAT);
    assign wr_data = reg_wr && (reg_addr == `UED_A_DATA);

    // ----------------------------------------
    // Bit rate tick
    // ----------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            div_r <= 1'b0;
        end else begin
            div_r <= ~div_r;
        end
    end

    always_comb begin
        case (mode)
            2'b00:   tick = 1'b1;
            2'b10:   tick = smod1_r | div_r;
            default: tick = baud_tick16;
        endcase
    end

    assign samp    = tick && (rx_tc_r == `UED_MID);
    assign low_nxt = rxd_in ? 4'h0 :
                     (low_r == `UED_BRK) ? low_r : low_r + 4'h1;
    assign ninth_ok = !(sm2_r && !rx_b9_r);
    assign tx_end  = tick && (tx_tc_r == `UED_LAST);

    // ----------------------------------------
    // Receiver
    // ----------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rx_st_r   <= RX_IDLE;
            rx_tc_r   <= 4'h0;
            rx_bit_r  <= 3'h0;
            rx_sh_r   <= `UED_RST8;
            rx_b9_r   <= 1'b0;
            low_r     <= 4'h0;
            ri_ev_r   <= 1'b0;
            fe_ev_r   <= 1'b0;
            br_ev_r   <= 1'b0;
            oe_ev_r   <= 1'b0;
            rb8_ev_r  <= 1'b0;
            rb8_val_r <= 1'b0;
            buf_val_r <= `UED_RST8;
        end else begin
            ri_ev_r  <= 1'b0;
            fe_ev_r  <= 1'b0;
            br_ev_r  <= 1'b0;
            oe_ev_r  <= 1'b0;
            rb8_ev_r <= 1'b0;
            if (tick && rx_st_r != RX_IDLE) begin
                rx_tc_r <= rx_tc_r + 4'h1;
            end
            if (samp && rx_st_r != RX_SHIFT) begin
                low_r <= low_nxt;
            end
            if (!ren_r && rx_st_r != RX_IDLE) begin
                rx_st_r <= RX_IDLE;
            end else begin
                case (rx_st_r)
                    RX_IDLE: begin
                        rx_tc_r  <= 4'h0;
                        rx_bit_r <= 3'h0;
                        low_r    <= 4'h0;
                        if (ren_r && mode == 2'b00 && !ri_r &&
                            !ri_ev_r && tx_st_r == TX_IDLE) begin
                            rx_st_r <= RX_SHIFT;
                        end else if (ren_r && mode != 2'b00 &&
                                     !rxd_in) begin
                            rx_st_r <= RX_START;
                        end
                    end
                    RX_START: begin
                        if (samp) begin
                            rx_st_r <= rxd_in ? RX_IDLE : RX_DATA;
                        end
                    end
                    RX_DATA: begin
                        if (samp) begin
                            rx_sh_r  <= {rxd_in, rx_sh_r[7:1]};
                            rx_bit_r <= rx_bit_r + 3'h1;
                            if (rx_bit_r == `UED_BIT7) begin
                                rx_st_r <= sm0_r ? RX_NINTH : RX_STOP;
                            end
                        end
                    end
                    RX_NINTH: begin
                        if (samp) begin
                            rx_b9_r <= rxd_in;
                            rx_st_r <= RX_STOP;
                            if (!frame_error_view_select_r) begin
                                rb8_ev_r  <= 1'b1;
                                rb8_val_r <= rxd_in;
                                buf_val_r <= rx_sh_r;
                                oe_ev_r   <= ri_r;
                                ri_ev_r   <= !(sm2_r && !rxd_in);
                            end
                        end
                    end
                    RX_STOP: begin
                        if (samp) begin
                            if (!sm0_r || frame_error_view_select_r) begin
                                rb8_ev_r  <= 1'b1;
                                rb8_val_r <= sm0_r ? rx_b9_r : rxd_in;
                                buf_val_r <= rx_sh_r;
                                oe_ev_r   <= ri_r;
                                ri_ev_r   <= !sm0_r || ninth_ok;
                            end
                            if (rxd_in) begin
                                rx_st_r <= RX_IDLE;
                            end else begin
                                fe_ev_r <= 1'b1;
                                br_ev_r <= (low_nxt == `UED_BRK);
                                rx_st_r <= RX_LOW;
                            end
                        end
                    end
                    RX_LOW: begin
                        if (samp) begin
                            if (rxd_in) begin
                                rx_st_r <= RX_IDLE;
                            end else if (low_nxt == `UED_BRK &&
                                         low_r != `UED_BRK) begin
                                br_ev_r <= 1'b1;
                                fe_ev_r <= 1'b1;
                            end
                        end
                    end
                    RX_SHIFT: begin
                        if (tick && rx_tc_r == `UED_LAST) begin
                            rx_sh_r  <= {rxd_in, rx_sh_r[7:1]};
                            rx_bit_r <= rx_bit_r + 3'h1;
                            if (rx_bit_r == `UED_BIT7) begin
                                buf_val_r <= {rxd_in, rx_sh_r[7:1]};
                                rb8_ev_r  <= 1'b1;
                                rb8_val_r <= 1'b0;
                                ri_ev_r   <= 1'b1;
                                rx_st_r   <= RX_IDLE;
                            end
                        end
                    end
                    default: rx_st_r <= RX_IDLE;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Transmitter
    // ----------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tx_st_r  <= TX_IDLE;
            tx_tc_r  <= 4'h0;
            tx_bit_r <= 3'h0;
            tx_sh_r  <= `UED_RST8;
            tx_b9_r  <= 1'b0;
            ti_ev_r  <= 1'b0;
        end else begin
            ti_ev_r <= 1'b0;
            if (tick && tx_st_r != TX_IDLE) begin
                tx_tc_r <= tx_tc_r + 4'h1;
            end
            case (tx_st_r)
                TX_IDLE: begin
                    tx_tc_r  <= 4'h0;
                    tx_bit_r <= 3'h0;
                    if (wr_data && rx_st_r != RX_SHIFT) begin
                        tx_sh_r <= reg_wdata;
                        tx_b9_r <= tb8_r;
                        tx_st_r <= (mode == 2'b00) ? TX_SHIFT : TX_START;
                    end
                end
                TX_START: begin
                    if (tx_end) begin
                        tx_st_r <= TX_DATA;
                    end
                end
                TX_DATA: begin
                    if (tx_end) begin
                        tx_sh_r  <= {1'b0, tx_sh_r[7:1]};
                        tx_bit_r <= tx_bit_r + 3'h1;
                        if (tx_bit_r == `UED_BIT7) begin
                            tx_st_r <= sm0_r ? TX_NINTH : TX_STOP;
                            ti_ev_r <= !sm0_r && !tx_irq_timing_select_r;
                        end
                    end
                end
                TX_NINTH: begin
                    if (tx_end) begin
                        tx_st_r <= TX_STOP;
                        ti_ev_r <= !tx_irq_timing_select_r;
                    end
                end
                TX_STOP: begin
                    if (tx_end) begin
                        tx_st_r <= TX_IDLE;
                        ti_ev_r <= tx_irq_timing_select_r;
                    end
                end
                TX_SHIFT: begin
                    if (tx_end) begin
                        tx_sh_r  <= {1'b0, tx_sh_r[7:1]};
                        tx_bit_r <= tx_bit_r + 3'h1;
                        if (tx_bit_r == `UED_BIT7) begin
                            tx_st_r <= TX_IDLE;
                            ti_ev_r <= 1'b1;
                        end
                    end
                end
                default: tx_st_r <= TX_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Pin drive
    // ----------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            txd_r  <= 1'b1;
            rxo_r  <= 1'b1;
            rxoe_r <= 1'b0;
        end else begin
            rxo_r  <= tx_sh_r[0];
            rxoe_r <= (tx_st_r == TX_SHIFT);
            case (tx_st_r)
                TX_START: txd_r <= 1'b0;
                TX_DATA:  txd_r <= tx_sh_r[0];
                TX_NINTH: txd_r <= tx_b9_r;
                TX_SHIFT: txd_r <= tx_tc_r[3];
                default:  txd_r <= (rx_st_r == RX_SHIFT) ? rx_tc_r[3] : 1'b1;
            endcase
        end
    end

    // ----------------------------------------
    // Control register flags
    // ----------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sm0_r <= 1'b0;
            sm1_r <= 1'b0;
            sm2_r <= 1'b0;
            ren_r <= 1'b0;
            tb8_r <= 1'b0;
            rb8_r <= 1'b0;
            ti_r  <= 1'b0;
            ri_r  <= 1'b0;
        end else begin
            if (wr_ctl) begin
                if (!frame_error_view_select_r) begin
                    sm0_r <= reg_wdata[7];
                end
                sm1_r <= reg_wdata[6];
                sm2_r <= reg_wdata[5];
                ren_r <= reg_wdata[4];
                tb8_r <= reg_wdata[3];
            end
            if (rb8_ev_r) begin
                rb8_r <= rb8_val_r;
            end else if (wr_ctl) begin
                rb8_r <= reg_wdata[2];
            end
            ti_r <= (wr_ctl ? reg_wdata[1] : ti_r) | ti_ev_r;
            ri_r <= (wr_ctl ? reg_wdata[0] : ri_r) | ri_ev_r;
        end
    end

    // ----------------------------------------
    // Status register flags
    // ----------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fe_r     <= 1'b0;
            br_r     <= 1'b0;
            oe_r     <= 1'b0;
            status_irq_enable_r  <= 1'b0;
            double_buffer_enable_r  <= 1'b0;
            tx_irq_timing_select_r  <= 1'b0;
            combined_irq_disable_r  <= 1'b0;
            double_buffer_irq_select_r <= 1'b0;
        end else begin
            if (wr_stat) begin
                double_buffer_enable_r  <= reg_wdata[7];
                tx_irq_timing_select_r  <= reg_wdata[6];
                combined_irq_disable_r  <= reg_wdata[5];
                double_buffer_irq_select_r <= reg_wdata[4];
                status_irq_enable_r  <= reg_wdata[0];
            end
            if (wr_stat) begin
                fe_r <= reg_wdata[`UED_B_FE] | fe_ev_r;
            end else if (wr_ctl && frame_error_view_select_r) begin
                fe_r <= reg_wdata[7] | fe_ev_r;
            end else begin
                fe_r <= fe_r | fe_ev_r | br_ev_r;
            end
            br_r <= (wr_stat ? reg_wdata[2] : br_r) | br_ev_r;
            oe_r <= (wr_stat ? reg_wdata[1] : oe_r) | oe_ev_r;
        end
    end

    // ----------------------------------------
    // Power and auxiliary control
    // ----------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            smod1_r <= 1'b0;
            frame_error_view_select_r <= 1'b0;
            break_reset_enable_r  <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == `UED_A_PWR) begin
                smod1_r <= reg_wdata[`UED_B_SMOD1];
                frame_error_view_select_r <= reg_wdata[`UED_B_FRAME_ERROR_VIEW_SELECT];
            end
            if (reg_wr && reg_addr == `UED_A_AUX) begin
                break_reset_enable_r <= reg_wdata[`UED_B_BREAK_RESET_ENABLE];
            end
        end
    end

    // ----------------------------------------
    // Receive buffer
    // ----------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rx_buf_r <= `UED_RST8;
        end else if (rb8_ev_r) begin
            rx_buf_r <= buf_val_r;
        end
    end

    // ----------------------------------------
    // Read port
    // ----------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= `UED_RST8;
        end else if (reg_rd) begin
            case (reg_addr)
                `UED_A_CTL:  rdata_r <= {frame_error_view_select_r ? fe_r : sm0_r,
                                         sm1_r, sm2_r, ren_r, tb8_r,
                                         rb8_r, ti_r, ri_r};
                `UED_A_STAT: rdata_r <= {double_buffer_enable_r, tx_irq_timing_select_r, combined_irq_disable_r,
                                         double_buffer_irq_select_r, fe_r, br_r, oe_r,
                                         status_irq_enable_r};
                `UED_A_PWR:  rdata_r <= {smod1_r, frame_error_view_select_r, 6'h00};
                `UED_A_AUX:  rdata_r <= {1'b0, break_reset_enable_r, 6'h00};
                `UED_A_DATA: rdata_r <= rx_buf_r;
                default:     rdata_r <= `UED_RST8;
            endcase
        end else begin
            rdata_r <= `UED_RST8;
        end
    end

    // ----------------------------------------
    // Interrupt and break reset
    // ----------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq_r  <= 1'b0;
            brst_r <= 1'b0;
            isp_r  <= 1'b0;
        end else begin
            irq_r  <= ri_r | ti_r | (status_irq_enable_r & (fe_r | br_r | oe_r));
            brst_r <= br_ev_r & break_reset_enable_r;
            isp_r  <= br_ev_r & break_reset_enable_r;
        end
    end

    assign reg_rdata     = rdata_r;
    assign txd_out       = txd_r;
    assign rxd_out       = rxo_r;
    assign rxd_oe        = rxoe_r;
    assign serial_irq    = irq_r;
    assign brk_reset_req = brst_r;
    assign isp_entry_req = isp_r;

endmodule : ued_uart

/* verif/ued_uart_assertions.sv */
`timescale 1ns/100ps
module ued_uart_assertions (
    // Clock and reset
    input wire logic       mclk,
    input wire logic       rst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // Line and system
    input wire logic       baud_tick16,
    input wire logic       rxd_in,
    input wire logic       rxd_oe,
    input wire logic       txd_out,
    input wire logic       serial_irq,
    input wire logic       brk_reset_req,
    input wire logic       isp_entry_req
);
    logic       view_r;
    logic       rd_ct_r;
    logic       rd_st_r;
    logic [1:0] mode_r;
    logic [7:0] low_r;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Shadow of view select, mode and read strobes
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            view_r  <= 1'b0;
            mode_r  <= 2'h0;
            rd_ct_r <= 1'b0;
            rd_st_r <= 1'b0;
        end else begin
            rd_ct_r <= reg_rd && reg_addr == 8'h98;
            rd_st_r <= reg_rd && reg_addr == 8'hBA;
            if (reg_wr && reg_addr == 8'h87)
                view_r <= reg_wdata[6];
            if (reg_wr && reg_addr == 8'h98)
                mode_r <= {view_r ? mode_r[1] : reg_wdata[7], reg_wdata[6]};
        end
    end
    // Ticks of unbroken low line
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            low_r <= 8'h00;
        else if (rxd_in)
            low_r <= 8'h00;
        else if (baud_tick16 && low_r != 8'hFF)
            low_r <= low_r + 8'h01;
    end
    property p_isp_same; brk_reset_req == isp_entry_req; endproperty
    a_isp_same: assert property (p_isp_same)
        else $error("entry and reset differ");
    property p_brk_pulse; brk_reset_req |=> !brk_reset_req; endproperty
    a_brk_pulse: assert property (p_brk_pulse)
        else $error("break reset too long");
    property p_rst_val; $rose(rst_n) |-> txd_out && !serial_irq; endproperty
    a_rst_val: assert property (p_rst_val)
        else $error("bad reset state");
    property p_mode_wr;
        (reg_wr && reg_addr == 8'h98 && !view_r) ##2
        (reg_rd && reg_addr == 8'h98) |=>
        (reg_rdata >> 3) == ($past(reg_wdata, 3) >> 3);
    endproperty
    a_mode_wr: assert property (p_mode_wr)
        else $error("mode bits not read back");
    property p_oe_mode0; rxd_oe |-> $past(mode_r) == 2'h0; endproperty
    a_oe_mode0: assert property (p_oe_mode0)
        else $error("data pin driven outside mode 0");
    property p_brk_low; brk_reset_req && mode_r[0] |-> low_r >= 8'hA0; endproperty
    a_brk_low: assert property (p_brk_low)
        else $error("break too early");
    property p_stat_irq; rd_st_r && reg_rdata[0] && |reg_rdata[3:1] |-> serial_irq; endproperty
    a_stat_irq: assert property (p_stat_irq)
        else $error("status irq missing");
    property p_done_irq; rd_ct_r && |reg_rdata[1:0] |-> serial_irq; endproperty
    a_done_irq: assert property (p_done_irq)
        else $error("done irq missing");
endmodule : ued_uart_assertions

bind ued_uart ued_uart_assertions u_chk (
    .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .baud_tick16(baud_tick16), .rxd_in(rxd_in),
    .rxd_oe(rxd_oe), .txd_out(txd_out), .serial_irq(serial_irq),
    .brk_reset_req(brk_reset_req), .isp_entry_req(isp_entry_req)
);

/* verif/ued_peer.sv */
`timescale 1ns/100ps
module ued_peer #(
    parameter int BT = 32
) (
    // Line
    input wire logic mclk,
    output logic     rxd,
    input wire logic txd
);
    initial rxd = 1'b1;
    // Bits LSB first, idle high after
    task automatic send(input logic [15:0] b, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge mclk);
            rxd <= b[i];
            repeat (BT - 1) @(posedge mclk);
        end
        @(posedge mclk);
        rxd <= 1'b1;
        // One bit time of idle so a line-low idle state sees the high bit
        repeat (BT) @(posedge mclk);
    endtask : send
    // Mid-bit sampling after start edge
    task automatic recv(output logic [8:0] d, input int n);
        int k;
        k = 0;
        d = 9'h000;
        while (txd !== 1'b0 && k < 9000) begin
            @(posedge mclk);
            k++;
        end
        repeat (BT / 2) @(posedge mclk);
        for (int i = 0; i < n; i++) begin
            repeat (BT) @(posedge mclk);
            d[i] = txd;
        end
    endtask : recv
endmodule : ued_peer

/* verif/ued_uart_tb.sv */
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
    $display("ERROR %0t got %h exp %h", $time, g, e); end end
module ued_uart_tb;
    logic       mclk = 1'b0;
    logic       rst_n = 1'b0;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic       baud_tick16 = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata, rv, d;
    logic [8:0] tv;
    logic       rxd_in, txd_out, serial_irq, brk_reset_req;
    logic [7:0] q[$];
    int         bad_count = 0;
    int         compares = 0;
    int         seed = 44;
    int         brk_seen = 0;
    always #12.5 mclk = ~mclk;
    always @(posedge mclk) baud_tick16 <= ~baud_tick16;
    always @(posedge mclk) if (brk_reset_req === 1'b1) brk_seen++;
    ued_uart u_dut (
        .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .baud_tick16(baud_tick16), .rxd_in(rxd_in),
        .rxd_out(), .rxd_oe(), .txd_out(txd_out), .serial_irq(serial_irq),
        .brk_reset_req(brk_reset_req), .isp_entry_req()
    );
    ued_peer #(.BT(32)) u_peer (.mclk(mclk), .rxd(rxd_in), .txd(txd_out));
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge mclk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd
    task frame(input logic [7:0] v, input logic n9, input logic s,
               input logic m3);
        if (m3)
            u_peer.send({5'h1F, s, n9, v, 1'b0}, 11);
        else
            u_peer.send({6'h3F, s, v, 1'b0}, 10);
    endtask : frame
    task getb;
        d = q.pop_front();
        rd(8'h99, rv);
        `CHK(rv, d)
    endtask : getb
    task tally_and_finish;
        if (bad_count == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (60000) @(posedge mclk);
        bad_count++;
        $display("ERROR %0t timeout", $time);
        tally_and_finish;
    end
    initial begin
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        rd(8'h98, rv); `CHK(rv, 8'h00)
        rd(8'hBA, rv); `CHK(rv[1:0], 2'h0)
        rd(8'h55, rv); `CHK(rv, 8'h00)
        wr(8'h98, 8'h50);
        rd(8'h98, rv); `CHK(rv, 8'h50)
        for (int i = 0; i < 3; i++) begin
            rv = 8'($random(seed));
            q.push_back(rv);
            frame(rv, 1'b0, 1'b1, 1'b0);
            getb();
            rd(8'h98, rv); `CHK(rv, 8'h55)
            wr(8'h98, 8'h50);
        end
        frame(8'hA5, 1'b0, 1'b1, 1'b0);
        frame(8'h3C, 1'b0, 1'b1, 1'b0);
        rd(8'hBA, rv); `CHK(rv[1], 1'b1)
        wr(8'hBA, 8'h00);
        frame(8'h0F, 1'b0, 1'b0, 1'b0);
        rd(8'hBA, rv); `CHK(rv[3], 1'b1)
        wr(8'h87, 8'h40);
        rd(8'h98, rv); `CHK(rv[7], 1'b1)
        wr(8'h98, 8'hD0);
        frame(8'h81, 1'b0, 1'b1, 1'b0);
        rd(8'hBA, rv); `CHK(rv[3], 1'b1)
        rd(8'h98, rv); `CHK(rv[7], 1'b1)
        wr(8'h98, 8'h50);
        wr(8'h87, 8'h00);
        wr(8'h98, 8'h40);
        frame(8'h77, 1'b0, 1'b1, 1'b0);
        rd(8'h98, rv); `CHK(rv[0], 1'b0)
        wr(8'hA2, 8'h40);
        wr(8'h98, 8'h50);
        wr(8'hBA, 8'h01);
        u_peer.send(16'h0000, 14);
        rd(8'hBA, rv); `CHK(rv[3:2], 2'h3)
        `CHK(serial_irq, 1'b1)
        `CHK(brk_seen, 1)
        wr(8'hBA, 8'h00);
        wr(8'h98, 8'h50);
        wr(8'hA2, 8'h00);
        @(posedge mclk);
        #1 `CHK(serial_irq, 1'b0)
        q.push_back(8'hC3);
        frame(8'hC3, 1'b0, 1'b1, 1'b0);
        getb();
        wr(8'h98, 8'h50);
        rv = 8'($random(seed));
        wr(8'h99, rv);
        u_peer.recv(tv, 9);
        repeat (24) @(posedge mclk);
        `CHK(tv, {1'b1, rv})
        rd(8'h98, rv); `CHK(rv[1], 1'b1)
        wr(8'h98, 8'hD8);
        wr(8'h99, 8'h5A);
        u_peer.recv(tv, 9);
        repeat (40) @(posedge mclk);
        `CHK(tv, 9'h15A)
        wr(8'h98, 8'hF0);
        frame(8'h11, 1'b0, 1'b1, 1'b1);
        rd(8'h98, rv); `CHK(rv[0], 1'b0)
        q.push_back(8'h22);
        frame(8'h22, 1'b1, 1'b1, 1'b1);
        rd(8'h98, rv); `CHK(rv[2:0], 3'h5)
        getb();
        wr(8'h98, 8'h00);
        wr(8'h99, 8'hE1);
        repeat (150) @(posedge mclk);
        rd(8'h98, rv); `CHK(rv[1], 1'b1)
        tally_and_finish;
    end
endmodule : ued_uart_tb
